// [dsc_ctrl_monitor.sv]
// port checker for the deep sleep controller, bound into its top module
// assumes one clock domain and the async active-low reset rst_n
`timescale 1ns/1ns
module dsc_ctrl_monitor #(
   parameter logic [7:0] POR_CYCLES = 8'h10
) (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic [4:0] avs_address,
   input wire logic avs_write,
   input wire logic master_clear_pin_n,
   input wire logic calendar_alarm,
   input wire logic calendar_enable,
   input wire logic pending_cpu_interrupt,
   input wire logic deep_sleep_active,
   input wire logic por_request,
   input wire logic io_hold,
   input wire logic irq_clear,
   input wire logic lowpower_wake
);
   logic [7:0] run_r;
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_n);
   // cycles the current power-on run has lasted
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n)
         run_r <= 8'h00;
      else if (por_request)
         run_r <= run_r + 8'h01;
      else
         run_r <= 8'h00;
   end
   lp_wake_cause_a: assert property (lowpower_wake |-> $past(pending_cpu_interrupt))
      else $error("low-power wake without pending interrupt");
   lp_wake_pulse_a: assert property (lowpower_wake |=> !lowpower_wake)
      else $error("low-power wake longer than a cycle");
   clear_pin_exit_a: assert property (
      deep_sleep_active && !master_clear_pin_n |-> ##[1:5] !deep_sleep_active)
      else $error("deep sleep kept with master clear low");
   alarm_exit_a: assert property (
      deep_sleep_active && calendar_alarm && calendar_enable |-> ##[1:5] !deep_sleep_active)
      else $error("deep sleep kept on enabled alarm");
   entry_state_a: assert property ($rose(deep_sleep_active) |-> io_hold && irq_clear)
      else $error("entry without hold or irq drop");
   irq_drop_only_a: assert property (irq_clear |-> $rose(deep_sleep_active))
      else $error("irq drop outside deep entry");
   exit_por_a: assert property ($fell(deep_sleep_active) |-> por_request)
      else $error("exit without power-on sequence");
   por_length_a: assert property ($fell(por_request) |-> run_r == POR_CYCLES)
      else $error("power-on sequence of wrong length");
   no_deep_por_a: assert property (por_request |-> !deep_sleep_active)
      else $error("deep sleep during power-on sequence");
   hold_frozen_a: assert property (
      io_hold && !(avs_write && avs_address[4:2] == 3'h0) |=> io_hold)
      else $error("pin hold dropped without a control write");
endmodule : dsc_ctrl_monitor

bind dsc_deep_sleep_ctrl dsc_ctrl_monitor #(.POR_CYCLES(POR_CYCLES)) u_dsc_ctrl_monitor (
   .clk(clk), .rst_n(rst_n), .avs_address(avs_address), .avs_write(avs_write),
   .master_clear_pin_n(master_clear_pin_n), .calendar_alarm(calendar_alarm),
   .calendar_enable(calendar_enable), .pending_cpu_interrupt(pending_cpu_interrupt),
   .deep_sleep_active(deep_sleep_active), .por_request(por_request), .io_hold(io_hold),
   .irq_clear(irq_clear), .lowpower_wake(lowpower_wake));

// [dsc_deep_sleep_ctrl.sv]
// deep sleep entry and exit controller with an avalon-mm register slave
// assumes cpu strobes and pending_cpu_interrupt come from logic on clk;
// pins, brownout detector, calendar alarm and watchdog timeout are asynchronous
//
// Behaviour
// - interrupt during sleep/idle instruction wakes afterwards
// - five events end deep sleep
// - arm bit self-clears after three idle cycles
// - arm bit clears on deep sleep exit
// - setting arm clears all wake flags
// - brownout watch only when config bit set
// - pending interrupt shown in status bit fifteen
// - master clear low exits deep sleep
// - calendar alarm wakes only when calendar enabled
// - external wake needs prior enable and edge
// - pending interrupt cleared on deep sleep entry
// - exit resets all but retained state
// - wakes during power-on sequence are ignored
// - exit sets exit flag, restarts at reset
// - brownout status readable in control bit one
// - pins stay frozen until hold cleared
// - brownout bit set on detected deep brownout
`timescale 1ns/1ns
`include "dsc_params.svh"
module dsc_deep_sleep_ctrl #(
   parameter logic [7:0] POR_CYCLES = `DSC_POR_SEQ_CYCLES
) (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic [4:0] avs_address,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic [31:0] avs_writedata,
   input wire logic [3:0] avs_byteenable,
   output logic [31:0] avs_readdata,
   output logic avs_waitrequest,
   input wire logic cpu_sleep_exec,
   input wire logic cpu_idle_exec,
   input wire logic pending_cpu_interrupt,
   input wire logic calendar_enable,
   input wire logic external_wake_enable,
   input wire logic external_wake_polarity,
   input wire logic external_wake_interrupt,
   input wire logic master_clear_pin_n,
   input wire logic calendar_alarm,
   input wire logic watchdog_timeout,
   input wire logic brownout_detect,
   input wire logic por_event,
   output logic deep_sleep_active,
   output logic por_request,
   output logic io_hold,
   output logic irq_clear,
   output logic lowpower_wake
);
   // last count of the arming window; at that edge an unused arm drops
   localparam logic [1:0] ARM_LAST = 2'(`DSC_ARM_WINDOW_TCY - 1);

   dsc_pkg::dsc_regs_type r_r;
   dsc_pkg::dsc_regs_type r_nxt;

   logic [31:0] mem_rdata;
   logic [31:0] wmask;
   logic [31:0] wdm;
   logic [5:0] raw_in;
   logic req;
   logic commit_wr;
   logic mem_sel_hit;
   logic ext_level;
   logic [4:0] wake;
   logic arm_wr;

   // asynchronous inputs gathered for the two-stage synchroniser
   assign raw_in = {por_event, calendar_alarm, brownout_detect, watchdog_timeout,
                    master_clear_pin_n, external_wake_interrupt};

   // byte lanes and bus qualifiers
   assign wmask = {{8{avs_byteenable[3]}}, {8{avs_byteenable[2]}},
                   {8{avs_byteenable[1]}}, {8{avs_byteenable[0]}}};
   assign wdm = avs_writedata & wmask;
   assign req = avs_read | avs_write;
   assign commit_wr = avs_write && (r_r.phase == 2'h2);
   assign mem_sel_hit = (avs_address[4:2] == 3'(`DSC_OFS_SCRATCH_A >> 2)) ||
                        (avs_address[4:2] == 3'(`DSC_OFS_SCRATCH_B >> 2));

   // software write to the arm lane; it restarts the window and beats the
   // expiry, so a re-arm in the last window cycle is not lost
   assign arm_wr = commit_wr && wmask[`DSC_BIT_ARM] &&
                   (avs_address[4:2] == 3'(`DSC_OFS_CONTROL >> 2));

   // asserted level of the external wake pin per its polarity setting
   assign ext_level = external_wake_polarity ? r_r.sync2[`DSC_SYN_EXT]
                                             : !r_r.sync2[`DSC_SYN_EXT];

   // wake sources, all taken from the second synchroniser stage
   always_comb begin
      wake = 5'h00;
      wake[`DSC_WAKE_POR] = r_r.sync2[`DSC_SYN_POR];
      wake[`DSC_WAKE_MASTER_CLEAR_PIN] = !r_r.sync2[`DSC_SYN_MASTER_CLEAR_PIN_N];
      wake[`DSC_WAKE_CALENDAR] = r_r.sync2[`DSC_SYN_CALENDAR] && calendar_enable;
      // a pin already asserted at entry gives no edge, so it cannot wake
      // enabled-at-entry edge only
      wake[`DSC_WAKE_EXT] = r_r.ext_armed && ext_level && !r_r.ext_prev;
      // config bit survives the exit, so later deep sleeps keep it
      // watchdog counts only when its config bit is programmed
      wake[`DSC_WAKE_WATCHDOG] = r_r.sync2[`DSC_SYN_WATCHDOG] &&
                                 r_r.cfg[`DSC_BIT_CFG_WATCHDOG];
   end

   // scratch words sit in their own memory so read data come from a register
   // scratch writes commit on the same edge as the register writes
   dsc_scratch_mem u_scratch (
      .clk(clk),
      .rst_n(rst_n),
      .sel(avs_address[2]),
      .wr_en(commit_wr && mem_sel_hit),
      .wr_mask(wmask),
      .wr_data(avs_writedata),
      .rd_data(mem_rdata)
   );

   // whole next-state function; bus writes first so hardware sets win after
   always_comb begin
      r_nxt = r_r;
      r_nxt.irq_clear = 1'b0;
      r_nxt.lp_wake = 1'b0;
      // stage one feeds only stage two; all logic reads stage two
      r_nxt.sync1 = raw_in;
      r_nxt.sync2 = r_r.sync1;
      // edge detector follows the asserted level, not the raw pin
      r_nxt.ext_prev = ext_level;
      r_nxt.irq_status = pending_cpu_interrupt;

      // bus handshake: seen, then read data loaded, then waitrequest low one cycle
      unique case (r_r.phase)
         2'h0: begin
            // held off while the internal power-on sequence runs
            if (req && (r_r.state != dsc_pkg::DSC_POR)) begin
               r_nxt.phase = 2'h1;
            end
         end
         2'h1: begin
            // read data loaded on the same edge that waitrequest drops
            r_nxt.phase = 2'h2;
            r_nxt.wait_req = 1'b0;
            r_nxt.rdata = `DSC_RST_WORD;
            if (avs_read) begin
               unique case (avs_address[4:2])
                  3'(`DSC_OFS_CONTROL >> 2): begin
                     r_nxt.rdata[`DSC_BIT_ARM] = r_r.arm;
                     r_nxt.rdata[`DSC_BIT_BROWNOUT] = r_r.brownout;
                     r_nxt.rdata[`DSC_BIT_IO_HOLD] = r_r.io_hold;
                  end
                  3'(`DSC_OFS_WAKE_FLAGS >> 2): begin
                     // upper bits read as zero
                     r_nxt.rdata[4:0] = r_r.wake_flags;
                  end
                  3'(`DSC_OFS_RESET_CONTROL >> 2): begin
                     r_nxt.rdata[`DSC_BIT_EXIT_FLAG] = r_r.exit_flag;
                  end
                  3'(`DSC_OFS_IRQ_STATUS >> 2): begin
                     // one cycle behind the cpu's pending level
                     r_nxt.rdata[`DSC_BIT_IRQ_PENDING] = r_r.irq_status;
                  end
                  3'(`DSC_OFS_SCRATCH_A >> 2), 3'(`DSC_OFS_SCRATCH_B >> 2): begin
                     r_nxt.rdata = mem_rdata;
                  end
                  3'(`DSC_OFS_CONFIG >> 2): begin
                     r_nxt.rdata[7:0] = r_r.cfg;
                  end
                  default: begin
                     // unmapped word reads as zero
                     r_nxt.rdata = `DSC_RST_WORD;
                  end
               endcase
            end
         end
         2'h2: begin
            // completing edge; write strobes act at this edge only
            r_nxt.phase = 2'h0;
            r_nxt.wait_req = 1'b1;
         end
         default: begin
            // code 3 is never entered; fall back to idle
            r_nxt.phase = 2'h0;
            r_nxt.wait_req = 1'b1;
         end
      endcase

      // register writes take effect at the edge that sees waitrequest low
      if (commit_wr) begin
         unique case (avs_address[4:2])
            3'(`DSC_OFS_CONTROL >> 2): begin
               if (wmask[`DSC_BIT_ARM]) begin
                  r_nxt.arm = wdm[`DSC_BIT_ARM];
                  r_nxt.win_cnt = 2'h0;
                  if (wdm[`DSC_BIT_ARM]) begin
                     r_nxt.wake_flags = 5'h00;
                  end
               end
               // write zero clears; a set in deep sleep wins over it
               if (wmask[`DSC_BIT_BROWNOUT] && !wdm[`DSC_BIT_BROWNOUT]) begin
                  r_nxt.brownout = 1'b0;
               end
               if (wmask[`DSC_BIT_IO_HOLD] && !wdm[`DSC_BIT_IO_HOLD]) begin
                  r_nxt.io_hold = 1'b0;
               end
            end
            3'(`DSC_OFS_WAKE_FLAGS >> 2): begin
               r_nxt.wake_flags = r_r.wake_flags & ~wdm[4:0];
            end
            3'(`DSC_OFS_RESET_CONTROL >> 2): begin
               // write one clears the exit flag
               if (wdm[`DSC_BIT_EXIT_FLAG]) begin
                  r_nxt.exit_flag = 1'b0;
               end
            end
            3'(`DSC_OFS_CONFIG >> 2): begin
               // lane 0 only; upper lanes hold no config bits
               r_nxt.cfg = (r_r.cfg & ~wmask[7:0]) | wdm[7:0];
            end
            default: begin
               // scratch words live in the memory; others ignore writes
               r_nxt.cfg = r_nxt.cfg;
            end
         endcase
      end

      // power state sequencing
      unique case (r_r.state)
         dsc_pkg::DSC_RUN: begin
            if (r_r.arm && cpu_sleep_exec) begin
               r_nxt.state = dsc_pkg::DSC_DEEP;
               r_nxt.deep_active = 1'b1;
               // hold rises with entry and only software drops it
               r_nxt.io_hold = 1'b1;
               r_nxt.irq_clear = 1'b1;
               r_nxt.irq_status = 1'b0;
               // enable is sampled now, later changes do not count
               r_nxt.ext_armed = external_wake_enable;
            end else if (r_r.arm) begin
               if (arm_wr) begin
                  // a software write this cycle owns arm and restarts the count
                  r_nxt.win_cnt = 2'h0;
               end else if (r_r.win_cnt == ARM_LAST) begin
                  r_nxt.arm = 1'b0;
               end else begin
                  r_nxt.win_cnt = r_r.win_cnt + 2'h1;
               end
            end else if (cpu_sleep_exec || cpu_idle_exec) begin
               // disarmed sleep or idle goes to ordinary low power
               r_nxt.state = dsc_pkg::DSC_LOWPWR;
            end
         end
         dsc_pkg::DSC_LOWPWR: begin
            // no timeout here; only an interrupt leaves ordinary low power
            // coincident interrupt wakes after entry
            if (pending_cpu_interrupt) begin
               r_nxt.state = dsc_pkg::DSC_RUN;
               r_nxt.lp_wake = 1'b1;
            end
         end
         dsc_pkg::DSC_DEEP: begin
            if (r_r.cfg[`DSC_BIT_CFG_BROWNOUT] && r_r.sync2[`DSC_SYN_BROWNOUT]) begin
               r_nxt.brownout = 1'b1;
            end
            if (|wake) begin
               // ored onto the post-write value, so a set beats a same-cycle clear
               // sticky per-source flags
               r_nxt.wake_flags = r_nxt.wake_flags | wake;
               r_nxt.arm = 1'b0;
               r_nxt.exit_flag = 1'b1;
               r_nxt.cfg = `DSC_RST_CONFIG;
               r_nxt.cfg[`DSC_BIT_CFG_WATCHDOG] = r_r.cfg[`DSC_BIT_CFG_WATCHDOG];
               r_nxt.irq_status = 1'b0;
               r_nxt.ext_armed = 1'b0;
               r_nxt.deep_active = 1'b0;
               r_nxt.por_req = 1'b1;
               r_nxt.por_cnt = 8'h00;
               r_nxt.state = dsc_pkg::DSC_POR;
            end
         end
         dsc_pkg::DSC_POR: begin
            r_nxt.irq_status = 1'b0;
            // counter starts at zero, so the request stands POR_CYCLES cycles
            if (r_r.por_cnt == POR_CYCLES - 8'h01) begin
               r_nxt.por_req = 1'b0;
               r_nxt.state = dsc_pkg::DSC_RUN;
            end else begin
               r_nxt.por_cnt = r_r.por_cnt + 8'h01;
            end
         end
      endcase
   end

   // scratch words are kept in their own module and survive a deep exit
   // single state register; true power-on reset clears it, except waitrequest and the master clear sync bits, which it sets
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         r_r <= '0;
         r_r.state <= dsc_pkg::DSC_RUN;
         r_r.cfg <= `DSC_RST_CONFIG;
         r_r.wait_req <= 1'b1;
         // master clear idles high, so no false wake out of reset
         r_r.sync1 <= 6'h02;
         r_r.sync2 <= 6'h02;
      end else begin
         r_r <= r_nxt;
      end
   end

   // no output has a combinational path from any input
   // every output straight from the state register
   assign avs_readdata = r_r.rdata;
   assign avs_waitrequest = r_r.wait_req;
   assign deep_sleep_active = r_r.deep_active;
   assign por_request = r_r.por_req;
   assign io_hold = r_r.io_hold;
   assign irq_clear = r_r.irq_clear;
   assign lowpower_wake = r_r.lp_wake;

endmodule : dsc_deep_sleep_ctrl

// [dsc_params.svh]
// offsets, field positions, reset values and cycle counts of the deep sleep controller
// assumes a 250 MHz instruction clock, one instruction cycle per clock
`ifndef DSC_PARAMS_SVH
`define DSC_PARAMS_SVH

// register byte offsets on the avalon slave
`define DSC_OFS_CONTROL 5'h00
`define DSC_OFS_WAKE_FLAGS 5'h04
`define DSC_OFS_RESET_CONTROL 5'h08
`define DSC_OFS_IRQ_STATUS 5'h0c
`define DSC_OFS_SCRATCH_A 5'h10
`define DSC_OFS_SCRATCH_B 5'h14
`define DSC_OFS_CONFIG 5'h18

// field positions
`define DSC_BIT_ARM 15
`define DSC_BIT_BROWNOUT 1
`define DSC_BIT_IO_HOLD 0
`define DSC_BIT_EXIT_FLAG 10
`define DSC_BIT_IRQ_PENDING 15
`define DSC_BIT_CFG_BROWNOUT 6
`define DSC_BIT_CFG_WATCHDOG 7

// wake flag positions
`define DSC_WAKE_POR 0
`define DSC_WAKE_MASTER_CLEAR_PIN 1
`define DSC_WAKE_CALENDAR 2
`define DSC_WAKE_EXT 3
`define DSC_WAKE_WATCHDOG 4

// synchroniser lanes
`define DSC_SYN_EXT 0
`define DSC_SYN_MASTER_CLEAR_PIN_N 1
`define DSC_SYN_WATCHDOG 2
`define DSC_SYN_BROWNOUT 3
`define DSC_SYN_CALENDAR 4
`define DSC_SYN_POR 5

// reset values
`define DSC_RST_CONFIG 8'h00
`define DSC_RST_WORD 32'h0000_0000

// arming window in instruction cycles
`define DSC_ARM_WINDOW_TCY 3
// length of the internal power-on sequence after a deep sleep exit
`define DSC_POR_SEQ_CYCLES 8'h10

`endif

// [dsc_partner.sv]
// firmware strobes and wake pins facing the deep sleep controller
// assumes callers enter each task just after a rising clk edge
`timescale 1ns/1ns
module dsc_partner (
   input wire logic clk,
   output logic cpu_sleep_exec,
   output logic cpu_idle_exec,
   output logic pending_cpu_interrupt,
   output logic calendar_enable,
   output logic external_wake_enable,
   output logic external_wake_interrupt,
   output logic master_clear_pin_n,
   output logic calendar_alarm,
   output logic watchdog_timeout,
   output logic brownout_detect,
   output logic por_event
);
   // por, clear, alarm, ext, watchdog, brownout, irq, cal en, ext en, sleep, idle
   logic [10:0] pin = 11'h000;
   // master clear is the only active-low pin
   assign por_event = pin[0];
   assign master_clear_pin_n = ~pin[1];
   assign calendar_alarm = pin[2];
   assign external_wake_interrupt = pin[3];
   assign watchdog_timeout = pin[4];
   assign brownout_detect = pin[5];
   assign pending_cpu_interrupt = pin[6];
   assign calendar_enable = pin[7];
   assign external_wake_enable = pin[8];
   assign cpu_sleep_exec = pin[9];
   assign cpu_idle_exec = pin[10];
   // no-op spacing, irq pin left as it is meanwhile
   task automatic power_save(input logic idle, input int nops);
      repeat (nops) @(posedge clk);
      pin[9] <= ~idle;
      pin[10] <= idle;
      @(posedge clk);
      pin[10:9] <= 2'b00;
   endtask : power_save
   // caller code goes on whether or not entry happened
   task automatic drive(input int idx, input logic lvl);
      pin[idx] <= lvl;
      @(posedge clk);
   endtask : drive
endmodule : dsc_partner

// [dsc_pkg.sv]
// types of the deep sleep entry and exit controller
// assumes dsc_params.svh is compiled alongside
package dsc_pkg;

   typedef enum logic [1:0] {
      DSC_RUN = 2'b00,
      DSC_LOWPWR = 2'b01,
      DSC_DEEP = 2'b10,
      DSC_POR = 2'b11
   } dsc_state_type;

   typedef struct packed {
      dsc_state_type state;
      logic [1:0] win_cnt;
      logic arm;
      logic brownout;
      logic io_hold;
      logic [4:0] wake_flags;
      logic exit_flag;
      logic irq_status;
      logic [7:0] cfg;
      logic [7:0] por_cnt;
      logic ext_armed;
      logic ext_prev;
      logic [5:0] sync1;
      logic [5:0] sync2;
      logic [1:0] phase;
      logic wait_req;
      logic [31:0] rdata;
      logic deep_active;
      logic por_req;
      logic irq_clear;
      logic lp_wake;
   } dsc_regs_type;

   typedef struct packed {
      logic [1:0][31:0] word;
      logic [31:0] rdata;
   } dsc_mem_type;

endpackage : dsc_pkg

// [dsc_scratch_mem.sv]
// two retained scratch words with registered read data
// assumes rst_n is only the true power-on reset; a deep sleep exit does not touch it
`timescale 1ns/1ns
module dsc_scratch_mem (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic sel,
   input wire logic wr_en,
   input wire logic [31:0] wr_mask,
   input wire logic [31:0] wr_data,
   output logic [31:0] rd_data
);
   dsc_pkg::dsc_mem_type m_r;
   dsc_pkg::dsc_mem_type m_nxt;

   // masked write, read always registered
   always_comb begin
      m_nxt = m_r;
      if (wr_en) begin
         m_nxt.word[sel] = (m_r.word[sel] & ~wr_mask) | (wr_data & wr_mask);
      end
      m_nxt.rdata = m_r.word[sel];
   end

   // contents survive everything but the true power-on reset
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         m_r <= '0;
      end else begin
         m_r <= m_nxt;
      end
   end

   assign rd_data = m_r.rdata;

endmodule : dsc_scratch_mem

// [tb_dsc_deep_sleep_ctrl.sv]
// self-checking bench for the deep sleep entry and exit controller
// assumes design, partner and monitor files compiled before it
`timescale 1ns/1ns
module tb_dsc_deep_sleep_ctrl;
   logic clk = 1'b0;
   logic rst_n = 1'b0;
   logic [4:0] avs_address = 5'h00;
   logic avs_read = 1'b0;
   logic avs_write = 1'b0;
   logic [31:0] avs_writedata = 32'h0000_0000;
   logic [3:0] avs_byteenable = 4'hf;
   logic ext_pol = 1'b1;
   logic [31:0] avs_readdata;
   logic avs_waitrequest, cpu_sleep_exec, cpu_idle_exec, pending_cpu_interrupt;
   logic calendar_enable, external_wake_enable, external_wake_interrupt, master_clear_pin_n;
   logic calendar_alarm, watchdog_timeout, brownout_detect, por_event;
   logic deep_sleep_active, por_request, io_hold, irq_clear, lowpower_wake;
   int fail_count = 0;
   int compares = 0;
   int lpw_n = 0;
   always #2 clk = ~clk;
   // wake pulses stand one cycle, so count them as they pass
   always @(posedge clk) if (lowpower_wake === 1'b1) lpw_n++;
   // short power-on run keeps the bench quick
   dsc_deep_sleep_ctrl #(.POR_CYCLES(8'h04)) u_dsc_deep_sleep_ctrl (
      .clk, .rst_n, .avs_address, .avs_read, .avs_write, .avs_writedata,
      .avs_byteenable, .avs_readdata, .avs_waitrequest, .cpu_sleep_exec,
      .cpu_idle_exec, .pending_cpu_interrupt, .calendar_enable, .external_wake_enable,
      .external_wake_polarity(ext_pol), .external_wake_interrupt, .master_clear_pin_n,
      .calendar_alarm, .watchdog_timeout, .brownout_detect, .por_event,
      .deep_sleep_active, .por_request, .io_hold, .irq_clear, .lowpower_wake);
   dsc_partner u_dsc_partner (
      .clk, .cpu_sleep_exec, .cpu_idle_exec, .pending_cpu_interrupt, .calendar_enable,
      .external_wake_enable, .external_wake_interrupt, .master_clear_pin_n,
      .calendar_alarm, .watchdog_timeout, .brownout_detect, .por_event);
   task automatic check(input logic [31:0] got, input logic [31:0] exp);
      compares++;
      if (got !== exp) begin
         fail_count++;
         $display("MISMATCH at %0t: got %h, expected %h", $time, got, exp);
      end
   endtask : check
   task automatic close_out;
      $display("compares %0d, mismatches %0d", compares, fail_count);
      if (fail_count == 0 && compares > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask : close_out
   // one avalon access; held until the edge that sees waitrequest low
   // an edge passes first, so back-to-back calls never drive twice at once
   task automatic bus(input logic wr, input logic [4:0] a, input logic [31:0] d,
                      output logic [31:0] q);
      @(posedge clk);
      avs_address <= a;
      avs_writedata <= d;
      avs_write <= wr;
      avs_read <= ~wr;
      do begin
         @(posedge clk);
      end while (avs_waitrequest !== 1'b0);
      q = avs_readdata;
      avs_write <= 1'b0;
      avs_read <= 1'b0;
   endtask : bus
   task automatic wr(input logic [4:0] a, input logic [31:0] d);
      logic [31:0] q;
      bus(1'b1, a, d, q);
   endtask : wr
   task automatic rd(input logic [4:0] a, input logic [31:0] exp);
      logic [31:0] q;
      bus(1'b0, a, 32'h0000_0000, q);
      check(q, exp);
   endtask : rd
   task automatic pd(input int i, input logic v);
      u_dsc_partner.drive(i, v);
   endtask : pd
   // bounded wait on a level output, returns just after a rising edge
   task automatic wait_sig(input logic por, input logic v);
      int n;
      n = 0;
      @(negedge clk);
      while ((por ? por_request : deep_sleep_active) !== v && n < 50) begin
         @(negedge clk);
         n++;
      end
      check(32'(n < 50), 32'h0000_0001);
      @(posedge clk);
   endtask : wait_sig
   // reset values, unmapped place reads zero and ignores writes
   task automatic s_reset;
      for (int a = 0; a < 8; a++) rd(5'(a * 4), 32'h0000_0000);
      wr(5'h1c, 32'hffff_ffff);
      rd(5'h1c, 32'h0000_0000);
      avs_byteenable <= 4'h3;
      wr(5'h14, 32'hffff_ffff);
      avs_byteenable <= 4'hf;
      rd(5'h14, 32'h0000_ffff);
   endtask : s_reset
   // late power-save drops to ordinary sleep; interrupts wake it
   task automatic s_late;
      wr(5'h00, 32'h0000_8000);
      u_dsc_partner.power_save(1'b0, 3);
      pd(6, 1'b1);
      repeat (3) @(posedge clk);
      check(32'(deep_sleep_active), 32'h0000_0000);
      check(32'(lpw_n), 32'h0000_0001);
      rd(5'h00, 32'h0000_0000);
      rd(5'h0c, 32'h0000_8000);
      u_dsc_partner.power_save(1'b1, 0);
      repeat (3) @(posedge clk);
      check(32'(lpw_n), 32'h0000_0002);
      pd(6, 1'b0);
   endtask : s_late
   // each wake source in turn, with retained state checked after the run
   task automatic s_wake;
      pd(7, 1'b1);
      pd(8, 1'b1);
      for (int s = 0; s < 5; s++) begin
         wr(5'h10, 32'ha5a5_0000 + s);
         wr(5'h18, 32'h0000_0080);
         wr(5'h00, 32'h0000_8000);
         u_dsc_partner.power_save(1'b0, 2);
         wait_sig(1'b0, 1'b1);
         rd(5'h04, 32'h0000_0000);
         pd(s, 1'b1);
         pd(5, 1'b1);
         wait_sig(1'b0, 1'b0);
         wait_sig(1'b1, 1'b0);
         pd(s, 1'b0);
         pd(5, 1'b0);
         rd(5'h04, 32'h0000_0001 << s);
         rd(5'h00, 32'h0000_0001);
         check(32'(io_hold), 32'h0000_0001);
         rd(5'h08, 32'h0000_0400);
         rd(5'h10, 32'ha5a5_0000 + s);
         rd(5'h18, 32'h0000_0080);
         wr(5'h08, 32'h0000_0400);
         // hold released last, then a pause before re-arming
         wr(5'h00, 32'h0000_0000);
         repeat (3) @(posedge clk);
         check(32'(io_hold), 32'h0000_0000);
      end
   endtask : s_wake
   // disabled alarm and external wake stay quiet; brownout watch on; clear pin wakes
   task automatic s_negative;
      pd(7, 1'b0);
      pd(8, 1'b0);
      wr(5'h18, 32'h0000_0040);
      wr(5'h00, 32'h0000_8000);
      u_dsc_partner.power_save(1'b0, 0);
      wait_sig(1'b0, 1'b1);
      for (int i = 2; i < 6; i++) pd(i, i != 4);
      repeat (10) @(posedge clk);
      check(32'(deep_sleep_active), 32'h0000_0001);
      pd(1, 1'b1);
      wait_sig(1'b0, 1'b0);
      wait_sig(1'b1, 1'b0);
      for (int i = 1; i < 6; i++) pd(i, 1'b0);
      rd(5'h04, 32'h0000_0002);
      rd(5'h00, 32'h0000_0003);
      wr(5'h00, 32'h0000_0000);
   endtask : s_negative
   // low-asserted external wake: a high-to-low change in deep sleep wakes
   task automatic s_polarity;
      ext_pol <= 1'b0;
      pd(3, 1'b1);
      pd(8, 1'b1);
      wr(5'h00, 32'h0000_8000);
      u_dsc_partner.power_save(1'b0, 2);
      wait_sig(1'b0, 1'b1);
      pd(3, 1'b0);
      wait_sig(1'b0, 1'b0);
      wait_sig(1'b1, 1'b0);
      rd(5'h04, 32'h0000_0008);
      ext_pol <= 1'b1;
      wr(5'h00, 32'h0000_0000);
   endtask : s_polarity
   initial begin
      repeat (5) @(posedge clk);
      rst_n <= 1'b1;
      @(posedge clk);
      s_reset;
      s_late;
      s_wake;
      s_negative;
      s_polarity;
      close_out;
   end
   // hang guard, far above the few hundred cycles the run needs
   initial begin
      repeat (20000) @(posedge clk);
      fail_count++;
      $display("MISMATCH at %0t: run timed out", $time);
      close_out;
   end
endmodule : tb_dsc_deep_sleep_ctrl
